// ===== common/tdb_pkg.sv
// constants shared by the timer burst window and remap logic
`default_nettype none
package tdb_pkg;
    // register byte offsets
    localparam logic [7:0] TDB_CTRL_ONE_OFS = 8'h00;
    localparam logic [7:0] TDB_DCTRL_OFS = 8'h48;
    localparam logic [7:0] TDB_WINDOW_OFS = 8'h4C;
    localparam logic [7:0] TDB_OPT_OFS = 8'h50;
    localparam logic [7:0] TDB_WIDTH_OFS = 8'h54;
    localparam logic [7:0] TDB_STATUS_OFS = 8'h58;
    localparam logic [7:0] TDB_LAST_FWD_OFS = 8'h44;
    // burst control field layout
    localparam int TDB_BASE_LSB = 0;
    localparam int TDB_BASE_MSB = 4;
    localparam int TDB_LEN_LSB = 8;
    localparam int TDB_LEN_MSB = 12;
    localparam int TDB_FIELD_W = 5;
    localparam logic [4:0] TDB_LEN_MAX = 5'h11;
    // option register field layout
    localparam int TDB_CH4_LSB = 6;
    localparam int TDB_CH4_MSB = 7;
    localparam int TDB_TRG_LSB = 10;
    localparam int TDB_TRG_MSB = 11;
    // byte mode bit of the width register
    localparam int TDB_BYTE_BIT = 0;
    // reset values
    localparam logic [15:0] TDB_REG_RESET = 16'h0000;
    localparam logic [31:0] TDB_DATA_ZERO = 32'h0000_0000;
    // trigger one selector codes
    typedef enum logic [1:0] {
        TDB_TRG_TIMER8 = 2'b00,
        TDB_TRG_PTP = 2'b01,
        TDB_TRG_SOF = 2'b10,
        TDB_TRG_RSVD = 2'b11
    } tdb_trg_sel_e;
    // channel four selector codes
    typedef enum logic [1:0] {
        TDB_CH4_PIN = 2'b00,
        TDB_CH4_LSI = 2'b01,
        TDB_CH4_LSE = 2'b10,
        TDB_CH4_RTC = 2'b11
    } tdb_ch4_sel_e;
    // bus handshake states
    typedef enum logic [1:0] {
        TDB_ST_IDLE = 2'b00,
        TDB_ST_TGT = 2'b01,
        TDB_ST_ACK = 2'b10
    } tdb_state_e;
endpackage : tdb_pkg
`default_nettype wire

// ===== hw/tdb_remap.sv
// input remap selectors for trigger one and channel four
`timescale 1ns/1ns
`default_nettype none
module tdb_remap (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // selectors
    input wire logic [1:0] input_remap_select_trg,
    input wire logic [1:0] input_remap_select_ch4,
    // trigger sources
    input wire logic eighth_timer_trigger_output,
    input wire logic ptp_trigger,
    input wire logic usb_sof_pulse,
    // channel four sources
    input wire logic ch4_pin,
    input wire logic low_speed_internal_clock,
    input wire logic low_speed_external_clock,
    input wire logic rtc_wakeup_irq,
    // routed signals
    output logic second_timer_internal_trigger_one,
    output logic fifth_timer_channel_four_in
);
    import tdb_pkg::*;

    logic trg_next;
    logic ch4_next;

    always_comb begin
        unique case (tdb_trg_sel_e'(input_remap_select_trg))
            TDB_TRG_TIMER8: trg_next = eighth_timer_trigger_output;
            TDB_TRG_PTP: trg_next = ptp_trigger;
            TDB_TRG_SOF: trg_next = usb_sof_pulse;
            TDB_TRG_RSVD: trg_next = 1'b0; // reserved code routes nothing
        endcase
    end

    always_comb begin
        unique case (tdb_ch4_sel_e'(input_remap_select_ch4))
            TDB_CH4_PIN: ch4_next = ch4_pin;
            TDB_CH4_LSI: ch4_next = low_speed_internal_clock;
            TDB_CH4_LSE: ch4_next = low_speed_external_clock;
            TDB_CH4_RTC: ch4_next = rtc_wakeup_irq;
        endcase
    end

    // one flop of latency, keeps outputs glitch free
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            second_timer_internal_trigger_one <= 1'b0;
            fifth_timer_channel_four_in <= 1'b0;
        end else begin
            second_timer_internal_trigger_one <= trg_next;
            fifth_timer_channel_four_in <= ch4_next;
        end
    end
endmodule : tdb_remap
`default_nettype wire

// ===== hw/tdb_burst_window.sv
// timer dma burst access window with apb slave and input remap
//
// Behaviour
// - five-bit base offset counted in registers from control register one
// - five-bit burst length, transfers equal field plus one, up to eighteen
// - each window read or write is one transfer of a burst
// - window access goes to control register one plus (base plus index) times four
// - burst index advances by hardware each transfer, wraps at burst length
// - sixteen and eight bit transfers; in byte mode first write transfer uses the high byte, reads return the low byte
// - two-bit selector routes trigger one: timer8, ptp, usb sof, reserved
// - two-bit selector routes channel four: pin, lsi, lse, rtc wake-up
//
// Our own choice: register access over APB.
`timescale 1ns/1ns
`default_nettype none
module tdb_burst_window #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // timer register file port
    output logic tgt_req,
    output logic tgt_write,
    output logic [ADDR_W-1:0] tgt_addr,
    output logic [15:0] tgt_wdata,
    input wire logic [15:0] tgt_rdata,
    // remap sources
    input wire logic eighth_timer_trigger_output,
    input wire logic ptp_trigger,
    input wire logic usb_sof_pulse,
    input wire logic ch4_pin,
    input wire logic low_speed_internal_clock,
    input wire logic low_speed_external_clock,
    input wire logic rtc_wakeup_irq,
    // remapped signals
    output logic second_timer_internal_trigger_one,
    output logic fifth_timer_channel_four_in
);
    import tdb_pkg::*;

    // byte address of a burst transfer
    function automatic logic [ADDR_W-1:0] burst_addr(
        input logic [TDB_FIELD_W-1:0] base,
        input logic [TDB_FIELD_W-1:0] idx
    );
        logic [TDB_FIELD_W:0] sum;
        sum = {1'b0, base} + {1'b0, idx};
        burst_addr = ADDR_W'(TDB_CTRL_ONE_OFS) + ADDR_W'({sum, 2'b00});
    endfunction : burst_addr

    // true when an offset is served by the timer register file
    function automatic logic is_forward(input logic [ADDR_W-1:0] addr);
        is_forward = (addr <= ADDR_W'(TDB_LAST_FWD_OFS)) && (addr[1:0] == 2'b00);
    endfunction : is_forward

    // true when an offset is one of this block's own registers
    function automatic logic is_local(input logic [ADDR_W-1:0] addr);
        is_local = (addr == ADDR_W'(TDB_DCTRL_OFS)) || (addr == ADDR_W'(TDB_OPT_OFS))
            || (addr == ADDR_W'(TDB_WIDTH_OFS)) || (addr == ADDR_W'(TDB_STATUS_OFS));
    endfunction : is_local

    // registers
    logic [TDB_FIELD_W-1:0] burst_base_offset_reg;
    logic [TDB_FIELD_W-1:0] burst_length_reg;
    logic [TDB_FIELD_W-1:0] burst_index_reg;
    logic [1:0] trg_sel_reg;
    logic [1:0] ch4_sel_reg;
    logic byte_mode_reg;
    tdb_state_e state_reg;
    logic win_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic tgt_req_reg;
    logic tgt_write_reg;
    logic [ADDR_W-1:0] tgt_addr_reg;
    logic [15:0] tgt_wdata_reg;

    // decode of the request held on the bus
    logic setup_phase;
    logic done;
    logic hit_window;
    logic hit_forward;
    logic hit_local;
    logic wr_done;
    logic win_done;
    logic [15:0] win_wdata;
    logic [15:0] dctrl_view;
    logic [15:0] opt_view;
    logic [31:0] local_rdata;

    assign setup_phase = psel && !penable;
    assign done = psel && penable && pready_reg;
    assign hit_window = (paddr == ADDR_W'(TDB_WINDOW_OFS));
    assign hit_forward = is_forward(paddr);
    assign hit_local = is_local(paddr);
    assign wr_done = done && pwrite && !pslverr_reg;
    assign win_done = done && win_reg && !pslverr_reg;

    // reserved positions are built as zero
    always_comb begin
        dctrl_view = TDB_REG_RESET;
        dctrl_view[TDB_BASE_MSB:TDB_BASE_LSB] = burst_base_offset_reg;
        dctrl_view[TDB_LEN_MSB:TDB_LEN_LSB] = burst_length_reg;
    end

    always_comb begin
        opt_view = TDB_REG_RESET;
        opt_view[TDB_TRG_MSB:TDB_TRG_LSB] = trg_sel_reg;
        opt_view[TDB_CH4_MSB:TDB_CH4_LSB] = ch4_sel_reg;
    end

    // narrow data sits low, upper bits read zero
    always_comb begin
        local_rdata = TDB_DATA_ZERO;
        if (paddr == ADDR_W'(TDB_DCTRL_OFS)) begin
            local_rdata[15:0] = dctrl_view;
        end else if (paddr == ADDR_W'(TDB_OPT_OFS)) begin
            local_rdata[15:0] = opt_view;
        end else if (paddr == ADDR_W'(TDB_WIDTH_OFS)) begin
            local_rdata[TDB_BYTE_BIT] = byte_mode_reg;
        end else if (paddr == ADDR_W'(TDB_STATUS_OFS)) begin
            local_rdata[TDB_FIELD_W-1:0] = burst_index_reg;
        end
    end

    // in byte mode the first transfer of a burst takes the high byte
    always_comb begin
        win_wdata = pwdata[15:0];
        if (byte_mode_reg) begin
            if (burst_index_reg == '0) begin
                win_wdata = {8'h00, pwdata[15:8]};
            end else begin
                win_wdata = {8'h00, pwdata[7:0]};
            end
        end
    end

    // handshake sequencing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= TDB_ST_IDLE;
        end else begin
            unique case (state_reg)
                TDB_ST_IDLE: begin
                    if (setup_phase) begin
                        if (hit_window || hit_forward) begin
                            state_reg <= TDB_ST_TGT;
                        end else begin
                            state_reg <= TDB_ST_ACK;
                        end
                    end
                end
                TDB_ST_TGT: begin
                    state_reg <= TDB_ST_ACK;
                end
                TDB_ST_ACK: begin
                    state_reg <= TDB_ST_IDLE;
                end
                default: begin
                    state_reg <= TDB_ST_IDLE;
                end
            endcase
        end
    end

    // decode result held for the whole transfer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_reg <= 1'b0;
        end else if (state_reg == TDB_ST_IDLE && setup_phase) begin
            win_reg <= hit_window;
        end
    end

    // target port: one request per forwarded or burst transfer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tgt_req_reg <= 1'b0;
            tgt_write_reg <= 1'b0;
            tgt_addr_reg <= '0;
            tgt_wdata_reg <= TDB_REG_RESET;
        end else if (state_reg == TDB_ST_IDLE && setup_phase && (hit_window || hit_forward)) begin
            tgt_req_reg <= 1'b1;
            tgt_write_reg <= pwrite;
            if (hit_window) begin
                tgt_addr_reg <= burst_addr(burst_base_offset_reg, burst_index_reg);
                tgt_wdata_reg <= win_wdata;
            end else begin
                tgt_addr_reg <= paddr;
                tgt_wdata_reg <= pwdata[15:0];
            end
        end else begin
            tgt_req_reg <= 1'b0;
            tgt_write_reg <= 1'b0;
        end
    end

    // apb answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= TDB_DATA_ZERO;
        end else begin
            unique case (state_reg)
                TDB_ST_IDLE: begin
                    if (setup_phase && !(hit_window || hit_forward)) begin
                        pready_reg <= 1'b1;
                        pslverr_reg <= !hit_local;
                        prdata_reg <= local_rdata;
                    end else begin
                        pready_reg <= 1'b0;
                        pslverr_reg <= 1'b0;
                    end
                end
                TDB_ST_TGT: begin
                    pready_reg <= 1'b1;
                    pslverr_reg <= 1'b0;
                    prdata_reg <= TDB_DATA_ZERO;
                    if (!tgt_write_reg) begin
                        if (byte_mode_reg && win_reg) begin
                            prdata_reg[7:0] <= tgt_rdata[7:0];
                        end else begin
                            prdata_reg[15:0] <= tgt_rdata;
                        end
                    end
                end
                TDB_ST_ACK: begin
                    pready_reg <= 1'b0;
                    pslverr_reg <= 1'b0;
                end
                default: begin
                    pready_reg <= 1'b0;
                    pslverr_reg <= 1'b0;
                end
            endcase
        end
    end

    // burst control register; a write restarts the burst index
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            burst_base_offset_reg <= '0;
            burst_length_reg <= '0;
        end else if (wr_done && paddr == ADDR_W'(TDB_DCTRL_OFS)) begin
            burst_base_offset_reg <= pwdata[TDB_BASE_MSB:TDB_BASE_LSB];
            burst_length_reg <= pwdata[TDB_LEN_MSB:TDB_LEN_LSB];
        end
    end

    // index moves on by itself, no software step needed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            burst_index_reg <= '0;
        end else if (wr_done && paddr == ADDR_W'(TDB_DCTRL_OFS)) begin
            burst_index_reg <= '0;
        end else if (win_done) begin
            // codes above the longest burst still wrap, so the index stays bounded
            if (burst_index_reg >= burst_length_reg || burst_index_reg >= TDB_LEN_MAX) begin
                burst_index_reg <= '0;
            end else begin
                burst_index_reg <= burst_index_reg + 1'b1;
            end
        end
    end

    // option register: only selector fields store
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trg_sel_reg <= 2'b00;
            ch4_sel_reg <= 2'b00;
        end else if (wr_done && paddr == ADDR_W'(TDB_OPT_OFS)) begin
            trg_sel_reg <= pwdata[TDB_TRG_MSB:TDB_TRG_LSB];
            ch4_sel_reg <= pwdata[TDB_CH4_MSB:TDB_CH4_LSB];
        end
    end

    // transfer width register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            byte_mode_reg <= 1'b0;
        end else if (wr_done && paddr == ADDR_W'(TDB_WIDTH_OFS)) begin
            byte_mode_reg <= pwdata[TDB_BYTE_BIT];
        end
    end

    tdb_remap u_remap (
        .pclk(pclk),
        .presetn(presetn),
        .input_remap_select_trg(trg_sel_reg),
        .input_remap_select_ch4(ch4_sel_reg),
        .eighth_timer_trigger_output(eighth_timer_trigger_output),
        .ptp_trigger(ptp_trigger),
        .usb_sof_pulse(usb_sof_pulse),
        .ch4_pin(ch4_pin),
        .low_speed_internal_clock(low_speed_internal_clock),
        .low_speed_external_clock(low_speed_external_clock),
        .rtc_wakeup_irq(rtc_wakeup_irq),
        .second_timer_internal_trigger_one(second_timer_internal_trigger_one),
        .fifth_timer_channel_four_in(fifth_timer_channel_four_in)
    );

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign tgt_req = tgt_req_reg;
    assign tgt_write = tgt_write_reg;
    assign tgt_addr = tgt_addr_reg;
    assign tgt_wdata = tgt_wdata_reg;
endmodule : tdb_burst_window
`default_nettype wire

// ===== bench/tdb_burst_window_sva.sv
// checker for the burst window apb slave and target port
`timescale 1ns/1ns
`default_nettype none
module tdb_burst_window_chk
    import tdb_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // target port
    input wire logic tgt_req,
    input wire logic [ADDR_W-1:0] tgt_addr
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_setup(logic [7:0] ofs);
        psel && !penable && paddr == ADDR_W'(ofs);
    endsequence
    sequence s_rd_ack(logic [7:0] ofs);
        pready && !pwrite && paddr == ADDR_W'(ofs);
    endsequence
    property p_win_req;
        s_setup(TDB_WINDOW_OFS) |=> tgt_req;
    endproperty
    a_win_req: assert property (p_win_req) else $error("window access made no target request");
    property p_win_ack;
        s_setup(TDB_WINDOW_OFS) ##1 tgt_req |=> pready ##1 !pready;
    endproperty
    a_win_ack: assert property (p_win_ack) else $error("window answer out of place");
    property p_fwd_addr;
        psel && !penable && paddr < ADDR_W'(TDB_DCTRL_OFS) && paddr[1:0] == 2'b00
            |=> tgt_req && tgt_addr == $past(paddr);
    endproperty
    a_fwd_addr: assert property (p_fwd_addr) else $error("forwarded address differs");
    property p_tgt_pulse;
        tgt_req |-> tgt_addr[1:0] == 2'b00 ##1 !tgt_req;
    endproperty
    a_tgt_pulse: assert property (p_tgt_pulse) else $error("target request malformed");
    property p_local;
        s_setup(TDB_DCTRL_OFS) |=> pready && !pslverr && !tgt_req;
    endproperty
    a_local: assert property (p_local) else $error("control register answer wrong");
    property p_dctrl_rsvd;
        s_rd_ack(TDB_DCTRL_OFS) |-> (prdata & 32'hFFFF_E0E0) == 32'h0000_0000;
    endproperty
    a_dctrl_rsvd: assert property (p_dctrl_rsvd) else $error("control reserved bits set");
    property p_opt_rsvd;
        s_rd_ack(TDB_OPT_OFS) |-> (prdata & 32'hFFFF_F33F) == 32'h0000_0000;
    endproperty
    a_opt_rsvd: assert property (p_opt_rsvd) else $error("option reserved bits set");
    property p_idx_bound;
        s_rd_ack(TDB_STATUS_OFS) |-> prdata[31:5] == 27'h0 && prdata[4:0] <= TDB_LEN_MAX;
    endproperty
    a_idx_bound: assert property (p_idx_bound) else $error("burst index out of range");
    property p_err;
        pslverr |-> pready && prdata == 32'h0000_0000;
    endproperty
    a_err: assert property (p_err) else $error("error answer carries data");
endmodule : tdb_burst_window_chk
bind tdb_burst_window tdb_burst_window_chk #(.ADDR_W(ADDR_W)) u_tdb_burst_window_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tgt_req(tgt_req), .tgt_addr(tgt_addr));
`default_nettype wire

// ===== bench/tdb_timer_regs.sv
// behavioural timer register file behind the target port
`timescale 1ns/1ns
`default_nettype none
module tdb_timer_regs (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // target port
    input wire logic tgt_req,
    input wire logic tgt_write,
    input wire logic [7:0] tgt_addr,
    input wire logic [15:0] tgt_wdata,
    output logic [15:0] tgt_rdata
);
    logic [15:0] mem_reg [64];
    logic [15:0] junk_reg;
    // data only valid with a request; a moving pattern otherwise exposes late sampling
    assign tgt_rdata = tgt_req ? mem_reg[tgt_addr[7:2]] : junk_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            junk_reg <= 16'h5A5A;
        end else begin
            junk_reg <= ~junk_reg ^ 16'h0001;
        end
    end
    always_ff @(posedge pclk) begin
        if (tgt_req && tgt_write) begin
            mem_reg[tgt_addr[7:2]] <= tgt_wdata;
        end
    end
endmodule : tdb_timer_regs
`default_nettype wire

// ===== bench/tdb_burst_window_tb_top.sv
// self-checking bench for the burst window, remap and registers
`timescale 1ns/1ns
`default_nettype none
`define TDB_CHK(nm, e, g) begin \
    checks_done++; \
    if ((g) !== (e)) begin \
        bad_count++; \
        $display("[ERR] %s expected %h seen %h", nm, e, g); \
    end \
end
module tdb_burst_window_tb_top;
    import tdb_pkg::*;
    typedef struct packed {
        logic chk;
        logic err;
        logic [31:0] d;
    } tdb_exp_s;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [6:0] srcs = 7'h00;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic tgt_req;
    logic tgt_write;
    logic [7:0] tgt_addr;
    logic [15:0] tgt_wdata;
    logic [15:0] tgt_rdata;
    logic trg_one;
    logic ch4_in;
    logic [31:0] seed = 32'h0001_7E67;
    logic [15:0] dat [4];
    logic [7:0] lofs [4] = '{8'h48, 8'h50, 8'h54, 8'h58};
    int bad_count = 0;
    int checks_done = 0;
    tdb_exp_s expq [$];
    tdb_exp_s cur;
    tdb_burst_window u_tdb_burst_window (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tgt_req(tgt_req), .tgt_write(tgt_write), .tgt_addr(tgt_addr),
        .tgt_wdata(tgt_wdata), .tgt_rdata(tgt_rdata),
        .eighth_timer_trigger_output(srcs[0]), .ptp_trigger(srcs[1]),
        .usb_sof_pulse(srcs[2]), .ch4_pin(srcs[3]), .low_speed_internal_clock(srcs[4]),
        .low_speed_external_clock(srcs[5]), .rtc_wakeup_irq(srcs[6]),
        .second_timer_internal_trigger_one(trg_one), .fifth_timer_channel_four_in(ch4_in));
    tdb_timer_regs u_tdb_timer_regs (
        .pclk(pclk), .presetn(presetn), .tgt_req(tgt_req), .tgt_write(tgt_write),
        .tgt_addr(tgt_addr), .tgt_wdata(tgt_wdata), .tgt_rdata(tgt_rdata));
    function logic [31:0] tdb_rand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : tdb_rand
    task test_done();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic chk, input logic [31:0] ed, input logic ee);
        expq.push_back(tdb_exp_s'{chk, ee, ed});
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no wait count assumed; a hang is ended by the watchdog
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr16(input logic [7:0] a, input logic [15:0] d);
        apb(1'b1, a, {16'h0000, d}, 1'b0, 32'h0000_0000, 1'b0);
    endtask : wr16
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000, 1'b1, e, 1'b0);
    endtask : rd
    // results are judged where they appear, against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            cur = expq.pop_front();
            `TDB_CHK("pslverr", cur.err, pslverr)
            if (cur.chk) `TDB_CHK("prdata", cur.d, prdata)
        end
    end
    initial begin
        forever #10 pclk = ~pclk;
    end
    initial begin
        repeat (5000) @(posedge pclk);
        bad_count++;
        test_done();
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 4; i++) rd(lofs[i], 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            wr16(TDB_OPT_OFS, 16'((i << 10) | (i << 6)) | 16'hF33F);
            rd(TDB_OPT_OFS, 32'((i << 10) | (i << 6)));
            for (int k = 0; k < 4; k++) begin
                @(posedge pclk);
                srcs <= 7'(tdb_rand());
                repeat (2) @(posedge pclk);
                `TDB_CHK("trigger one", (i == 3) ? 1'b0 : srcs[i], trg_one)
                `TDB_CHK("channel four", srcs[3 + i], ch4_in)
            end
        end
        // base three, three transfers; the fourth wraps to the base
        wr16(TDB_DCTRL_OFS, 16'hE2E3);
        rd(TDB_DCTRL_OFS, 32'h0000_0203);
        for (int j = 0; j < 4; j++) begin
            dat[j] = 16'(tdb_rand());
            wr16(TDB_WINDOW_OFS, dat[j]);
        end
        rd(TDB_STATUS_OFS, 32'h0000_0001);
        rd(8'h0C, {16'h0000, dat[3]});
        rd(8'h10, {16'h0000, dat[1]});
        rd(8'h14, {16'h0000, dat[2]});
        wr16(TDB_DCTRL_OFS, 16'h0203);
        for (int j = 0; j < 3; j++) rd(TDB_WINDOW_OFS, {16'h0000, dat[j == 0 ? 3 : j]});
        // longest burst, eighteen transfers from control register one
        wr16(TDB_DCTRL_OFS, {3'b000, TDB_LEN_MAX, 8'h00});
        for (int j = 0; j < 18; j++) wr16(TDB_WINDOW_OFS, 16'h0100 + 16'(j));
        rd(TDB_STATUS_OFS, 32'h0000_0000);
        rd(8'h44, 32'h0000_0111);
        rd(8'h00, 32'h0000_0100);
        // byte mode: first transfer carries the high byte
        wr16(TDB_WIDTH_OFS, 16'h0001);
        wr16(TDB_DCTRL_OFS, 16'h0101);
        wr16(TDB_WINDOW_OFS, 16'hABCD);
        wr16(TDB_WINDOW_OFS, 16'h1234);
        rd(8'h04, 32'h0000_00AB);
        rd(8'h08, 32'h0000_0034);
        rd(TDB_WINDOW_OFS, 32'h0000_00AB);
        apb(1'b0, 8'h5C, 32'h0000_0000, 1'b1, 32'h0000_0000, 1'b1);
        apb(1'b1, 8'h4E, 32'hFFFF_FFFF, 1'b0, 32'h0000_0000, 1'b1);
        rd(TDB_WIDTH_OFS, 32'h0000_0001);
        repeat (3) @(posedge pclk);
        test_done();
    end
endmodule : tdb_burst_window_tb_top
`default_nettype wire
